/* File: hw/mem_map_pkg.sv */
// Constants, field layout and mode encoding for the memory map and mode block
package mem_map_pkg;

    // Register byte addresses on the bus
    localparam logic [15:0] PRIO_MISC_OFFSET   = 16'h103c;
    localparam logic [15:0] MODE_STATUS_OFFSET = 16'h1040;

    // Field positions in mode_and_priority_misc
    localparam int BOOT_BIT = 7;
    localparam int SPECIAL_MODE_FLAG_BIT = 6;
    localparam int MDA_BIT  = 5;
    localparam int RV_BIT   = 4;
    localparam int PSEL_LSB = 0;
    localparam int PSEL_W   = 4;

    // Reset values
    localparam logic [3:0] PSEL_RESET    = 4'h6;
    localparam logic [3:0] EE_SEL_RESET  = 4'hf;

    // Fixed windows
    localparam logic [15:0] BOOT_ROM_LO  = 16'hbf00;
    localparam logic [15:0] BOOT_ROM_HI  = 16'hbfff;
    localparam logic [15:0] SMALL_EE_LO  = 16'hb600;
    localparam logic [15:0] SMALL_EE_HI  = 16'hb7ff;
    localparam int          BIG_EE_HALF  = 11;
    localparam logic [15:0] ROM_BASE_DEF = 16'hd000;

    // Reset vector blocks
    localparam logic [15:0] VEC_NORMAL   = 16'hfffa;
    localparam logic [15:0] VEC_SPECIAL  = 16'hbffa;

    // Operating modes, one-hot
    typedef enum logic [3:0]
    {
        MODE_SINGLE   = 4'b0001,
        MODE_EXPANDED = 4'b0010,
        MODE_BOOT     = 4'b0100,
        MODE_TEST     = 4'b1000
    } mode_e;

endpackage

/* File: hw/memory_map_and_mode_select.sv */
// Mode strap capture, resource decode and the mode/priority register
//
// Notes on behaviour
// - Register block beats RAM, RAM beats ROM at a shared address.
// - Only the winning resource is selected on an overlapping access.
// - Boot ROM decodes at BF00-BFFF while boot_rom_enable and special_mode_flag are both set.
// - Expanded modes enable program ROM only when rom_enable_cfg is set.
// - Single-chip and bootstrap always enable program ROM out of reset.
// - Small EEPROM sits fixed at B600-B7FF.
// - Large EEPROM defaults to F800-FFFF, movable to any 4K boundary.
// - eeprom_base_select is the top nibble; window covers x800-xFFF.
// - Mode pins are sampled only at reset; later changes ignored.
// - Mode-dependent register reset values follow the mode caught at reset.
// - special_mode_flag loads the inverse of mode_pin_b.
// - mode_select_a_flag loads the level of mode_pin_a.
// - Reset vectors at FFFA-FFFF normally, BFFA-BFFF in special modes.
// - Fetch marker pulls low the cycle after the first cycle of each instruction.
// - In special modes both mode flags are writable; always readable.
// - In normal modes mode_select_a_flag takes only the first write.
// - special_mode_flag once cleared cannot be set again.
// - boot_rom_enable writable only in special modes, acts while flag set.
// - read_visibility_or_clock_off takes exactly one write after reset.
// - Visibility bit resets to 1 in test mode, else 0.
// - Expanded/test: bit set drives internal reads onto external bus.
// - Single-chip/bootstrap: bit clear drives bus clock out, set holds low.

`timescale 1ns/10ps

module memory_map_and_mode_select
#(
    parameter bit          LARGE_EEPROM = 1'b0,
    parameter logic [15:0] ROM_BASE     = mem_map_pkg::ROM_BASE_DEF
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Strap pins and shared marker pin
    input  wire logic        mode_pin_a,
    input  wire logic        mode_pin_b,
    output logic             instruction_fetch_marker_out,
    output logic             instruction_fetch_marker_oe,
    // Startup configuration latches
    input  wire logic        rom_enable_cfg,
    input  wire logic [3:0]  eeprom_base_select,
    // Core access to decode
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_access,
    input  wire logic        reg_block_hit,
    input  wire logic        ram_hit,
    input  wire logic        instr_first_cycle,
    input  wire logic        bus_clock_phase,
    // Resource selects, one-hot, one cycle after the address
    output logic             sel_reg_block,
    output logic             sel_ram,
    output logic             sel_boot_rom,
    output logic             sel_eeprom,
    output logic             sel_program_rom,
    output logic             sel_external,
    // Mode outputs
    output logic      [15:0] reset_vector_addr,
    output logic      [3:0]  priority_select,
    output logic             read_visibility_drive,
    output logic             bus_clock_pin
);
    import mem_map_pkg::*;

    // Strap synchronisers run through reset so they hold the pin level
    logic       strap_a_meta;
    logic       strap_a_sync;
    logic       strap_b_meta;
    logic       strap_b_sync;
    logic       captured;
    mode_e      mode;
    mode_e      next_mode;
    logic       rom_on;
    logic       special_mode_flag;
    logic       mode_select_a_flag;
    logic       boot_rom_enable;
    logic       read_visibility_or_clock_off;
    logic       mda_written;
    logic       rv_written;
    logic [7:0] prio_misc;
    logic [7:0] wdata;
    logic       bus_req;
    logic       prio_hit;
    logic       status_hit;
    logic       prio_write;
    logic       in_boot;
    logic       in_small_ee;
    logic       in_big_ee;
    logic       in_eeprom;
    logic       in_rom;
    logic       single_or_boot;

    always_ff @(posedge clock)
    begin
        strap_a_meta <= mode_pin_a;
        strap_a_sync <= strap_a_meta;
        strap_b_meta <= mode_pin_b;
        strap_b_sync <= strap_b_meta;
    end

    always_comb
    begin
        unique case ({strap_b_sync, strap_a_sync})
            2'b10:   next_mode = MODE_SINGLE;
            2'b11:   next_mode = MODE_EXPANDED;
            2'b00:   next_mode = MODE_BOOT;
            default: next_mode = MODE_TEST;
        endcase
    end

    // Caught on the first edge after release, never again
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            captured <= 1'b0;
            mode     <= MODE_SINGLE;
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            mode     <= next_mode;
        end
    end

    assign single_or_boot = (mode == MODE_SINGLE) || (mode == MODE_BOOT);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rom_on <= 1'b0;
        else if (!captured)
            rom_on <= (next_mode == MODE_SINGLE) || (next_mode == MODE_BOOT)
                      || rom_enable_cfg;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            reset_vector_addr <= VEC_NORMAL;
        else if (!captured)
            reset_vector_addr <= strap_b_sync ? VEC_NORMAL : VEC_SPECIAL;
    end

    // Bus slave
    assign bus_req    = wb_cyc_i && wb_stb_i;
    assign prio_hit   = wb_adr_i[15:2] == PRIO_MISC_OFFSET[15:2];
    assign status_hit = wb_adr_i[15:2] == MODE_STATUS_OFFSET[15:2];
    assign wdata      = wb_dat_i[7:0];
    assign prio_write = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0]
                        && prio_hit && captured;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req && !wb_ack_o;
    end

    assign prio_misc = {boot_rom_enable, special_mode_flag,
                        mode_select_a_flag, read_visibility_or_clock_off,
                        priority_select};

    // Unmapped addresses read zero and still get an ack
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            wb_dat_o <= 32'h0;
        else if (bus_req && !wb_ack_o)
        begin
            if (prio_hit)
                wb_dat_o <= {24'h0, prio_misc};
            else if (status_hit)
                wb_dat_o <= {26'h0, rom_on, captured, mode};
            else
                wb_dat_o <= 32'h0;
        end
    end

    // Mode flags
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            special_mode_flag <= 1'b0;
        else if (!captured)
            special_mode_flag <= !strap_b_sync;
        else if (prio_write)
            special_mode_flag <= wdata[SPECIAL_MODE_FLAG_BIT] && special_mode_flag;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_select_a_flag <= 1'b0;
            mda_written        <= 1'b0;
        end
        else if (!captured)
            mode_select_a_flag <= strap_a_sync;
        else if (prio_write)
        begin
            mda_written <= 1'b1;
            if (special_mode_flag || !mda_written)
                mode_select_a_flag <= wdata[MDA_BIT];
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            boot_rom_enable <= 1'b0;
        else if (!captured)
            boot_rom_enable <= next_mode == MODE_BOOT;
        else if (prio_write && special_mode_flag)
            boot_rom_enable <= wdata[BOOT_BIT];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            read_visibility_or_clock_off <= 1'b0;
            rv_written                   <= 1'b0;
        end
        else if (!captured)
            read_visibility_or_clock_off <= next_mode == MODE_TEST;
        else if (prio_write && !rv_written)
        begin
            rv_written                   <= 1'b1;
            read_visibility_or_clock_off <= wdata[RV_BIT];
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            priority_select <= PSEL_RESET;
        else if (prio_write)
            priority_select <= wdata[PSEL_LSB +: PSEL_W];
    end

    // Resource decode
    assign in_boot = boot_rom_enable && special_mode_flag
                     && cpu_addr >= BOOT_ROM_LO
                     && cpu_addr <= BOOT_ROM_HI;

    assign in_small_ee = cpu_addr >= SMALL_EE_LO
                         && cpu_addr <= SMALL_EE_HI;

    // Top nibble from the select, upper half of that 4K page
    assign in_big_ee = cpu_addr[15:12] == eeprom_base_select
                       && cpu_addr[BIG_EE_HALF];

    assign in_eeprom = LARGE_EEPROM ? in_big_ee : in_small_ee;
    assign in_rom    = rom_on && cpu_addr >= ROM_BASE;

    // Registered so the selects come straight from flops
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_reg_block   <= 1'b0;
            sel_ram         <= 1'b0;
            sel_boot_rom    <= 1'b0;
            sel_eeprom      <= 1'b0;
            sel_program_rom <= 1'b0;
            sel_external    <= 1'b0;
        end
        else
        begin
            sel_reg_block   <= cpu_access && reg_block_hit;
            sel_ram         <= cpu_access && !reg_block_hit && ram_hit;
            sel_boot_rom    <= cpu_access && !reg_block_hit && !ram_hit
                               && in_boot;
            sel_eeprom      <= cpu_access && !reg_block_hit && !ram_hit
                               && !in_boot && in_eeprom;
            sel_program_rom <= cpu_access && !reg_block_hit && !ram_hit
                               && !in_boot && !in_eeprom && in_rom;
            sel_external    <= cpu_access && !reg_block_hit && !ram_hit
                               && !in_boot && !in_eeprom && !in_rom;
        end
    end

    // Open-drain marker: output level fixed low, only the enable moves
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            instruction_fetch_marker_out <= 1'b0;
            instruction_fetch_marker_oe  <= 1'b0;
        end
        else
        begin
            instruction_fetch_marker_out <= 1'b0;
            instruction_fetch_marker_oe  <= captured && instr_first_cycle;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            read_visibility_drive <= 1'b0;
            bus_clock_pin         <= 1'b0;
        end
        else
        begin
            read_visibility_drive <= !single_or_boot && captured
                                     && read_visibility_or_clock_off;
            bus_clock_pin         <= (!single_or_boot
                                      || !read_visibility_or_clock_off)
                                     && bus_clock_phase;
        end
    end

endmodule

/* File: tb/mem_map_sva.sv */
// Port-level assertions for the memory map and mode block
`timescale 1ns/10ps
module mem_map_sva
import mem_map_pkg::*;
#(
    parameter bit LARGE_EEPROM = 1'b0
)
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    // Core side
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_access,
    input wire logic        reg_block_hit,
    input wire logic        ram_hit,
    input wire logic        instr_first_cycle,
    input wire logic        bus_clock_phase,
    // Results
    input wire logic        sel_reg_block,
    input wire logic        sel_ram,
    input wire logic        sel_boot_rom,
    input wire logic        sel_eeprom,
    input wire logic        sel_program_rom,
    input wire logic        sel_external,
    input wire logic        instruction_fetch_marker_out,
    input wire logic        instruction_fetch_marker_oe,
    input wire logic [3:0]  priority_select,
    input wire logic        bus_clock_pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    reg_first_a: assert property (
        cpu_access && reg_block_hit |=> sel_reg_block && !sel_ram)
        else $error("register block lost to a lower resource");
    ram_first_a: assert property (
        cpu_access && ram_hit && !reg_block_hit
        |=> sel_ram && !sel_program_rom && !sel_eeprom)
        else $error("ram lost to a rom");
    one_sel_a: assert property (
        $onehot0({sel_reg_block, sel_ram, sel_boot_rom, sel_eeprom,
                  sel_program_rom, sel_external}))
        else $error("more than one resource selected");
    boot_win_a: assert property (
        sel_boot_rom |-> $past(cpu_addr[15:8]) == 8'hbf)
        else $error("boot rom selected outside its window");
    small_ee_a: assert property (
        !LARGE_EEPROM && cpu_access && !reg_block_hit && !ram_hit
        && cpu_addr[15:9] == 7'h5b |=> sel_eeprom)
        else $error("eeprom window missed");
    marker_a: assert property (
        instruction_fetch_marker_oe |-> $past(instr_first_cycle))
        else $error("fetch marker without a first cycle");
    marker_on_a: assert property (
        instr_first_cycle |=> instruction_fetch_marker_oe)
        else $error("fetch marker missing on first cycle");
    marker_low_a: assert property (
        instruction_fetch_marker_out == 1'b0)
        else $error("fetch marker driven high");
    clk_pin_a: assert property (
        bus_clock_pin |-> $past(bus_clock_phase))
        else $error("clock pin not from bus clock");
    psel_hold_a: assert property (
        $changed(priority_select) |-> $past(wb_we_i) || $past(wb_we_i, 2))
        else $error("priority select moved without a write");
    ack_next_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule

/* File: tb/core_model.sv */
// Behavioural processor core feeding the decode side of the block
`timescale 1ns/10ps
module core_model
(
    // Clock
    input  wire logic        clock,
    // Core bus
    output logic      [15:0] cpu_addr,
    output logic             cpu_access,
    output logic             reg_block_hit,
    output logic             ram_hit,
    output logic             instr_first_cycle,
    output logic             bus_clock_phase
);
    initial
    begin
        cpu_addr = 16'h0;
        cpu_access = 1'b0;
        reg_block_hit = 1'b0;
        ram_hit = 1'b0;
        instr_first_cycle = 1'b0;
        bus_clock_phase = 1'b0;
    end

    always @(posedge clock)
        bus_clock_phase <= ~bus_clock_phase;

    // One access per call, each the first cycle of an instruction
    task automatic access(logic [15:0] a, logic r, logic m);
        @(posedge clock);
        cpu_addr <= a;
        cpu_access <= 1'b1;
        reg_block_hit <= r;
        ram_hit <= m;
        instr_first_cycle <= 1'b1;
        @(posedge clock);
        cpu_access <= 1'b0;
        reg_block_hit <= 1'b0;
        ram_hit <= 1'b0;
        instr_first_cycle <= 1'b0;
        // Idle bus shows no stale address
        cpu_addr <= ~a;
    endtask
endmodule

/* File: tb/tb_memory_map_and_mode_select.sv */
// Self-checking bench for the memory map and mode block
`timescale 1ns/10ps
module tb_memory_map_and_mode_select;
import mem_map_pkg::*;
    logic        clock, rstn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [15:0] wb_adr_i, cpu_addr, reset_vector_addr;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  wb_sel_i, priority_select, eeprom_base_select;
    logic        mode_pin_a, mode_pin_b, rom_enable_cfg;
    logic        instruction_fetch_marker_out, instruction_fetch_marker_oe;
    logic        cpu_access, reg_block_hit, ram_hit;
    logic        instr_first_cycle, bus_clock_phase;
    logic        sel_reg_block, sel_ram, sel_boot_rom, sel_eeprom;
    logic        sel_program_rom, sel_external;
    logic        read_visibility_drive, bus_clock_pin;
    logic [31:0] exp_q[$];
    logic [15:0] seed = 16'h2d;
    logic [7:0]  rst_val[4] = '{8'hc6, 8'h76, 8'h06, 8'h26};
    // One-hot mode codes for boot, test, single, expanded straps
    logic [3:0]  mode_val[4] = '{4'h4, 4'h8, 4'h1, 4'h2};
    int          n_errors = 0;
    int          tests_run = 0;

    memory_map_and_mode_select u_dut (.*);
    core_model u_core (.*);

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [15:0] xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Straps are held through the whole reset so the synchronisers fill
    task automatic rst(logic [1:0] ba, logic cfg);
        @(posedge clock);
        rstn <= 1'b0;
        {mode_pin_b, mode_pin_a} <= ba;
        rom_enable_cfg <= cfg;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // Read passes the expected byte, write passes the data
    task automatic wb(logic we, logic [15:0] a, logic [7:0] d);
        int t;
        if (!we)
            exp_q.push_back({24'h0, d});
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        t = 0;
        do
        begin
            @(posedge clock);
            t++;
        end
        while (wb_ack_o !== 1'b1 && t < 20);
        if (t >= 20)
            n_errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask

    always @(posedge clock)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), wb_dat_o);

    task automatic dec(logic [15:0] a, logic r, logic m, logic [5:0] e);
        u_core.access(a, r, m);
        #1;
        chk("select", e, {sel_reg_block, sel_ram, sel_boot_rom,
            sel_eeprom, sel_program_rom, sel_external});
        @(posedge clock);
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        stop_test();
    end

    initial
    begin
        logic [15:0] r;
        logic        p;
        rstn = 1'b0;
        wb_adr_i = 16'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h1;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        mode_pin_a = 1'b0;
        mode_pin_b = 1'b1;
        rom_enable_cfg = 1'b0;
        eeprom_base_select = 4'hf;
        for (int k = 0; k < 8; k++)
        begin
            rst(k[1:0], k[2]);
            wb(1'b0, PRIO_MISC_OFFSET, rst_val[k%4]);
            chk("vector", k[1] ? VEC_NORMAL : VEC_SPECIAL, reset_vector_addr);
            chk("visibility", k%4 == 1, read_visibility_drive);
            wb(1'b0, MODE_STATUS_OFFSET,
               {2'b0, !k[0] || k[2], 1'b1, mode_val[k%4]});
            // Visibility bit is clear or mode ignores it: clock runs
            p = bus_clock_pin;
            @(posedge clock);
            chk("clock out", !p, bus_clock_pin);
            mode_pin_a <= ~mode_pin_a;
            mode_pin_b <= ~mode_pin_b;
            repeat (4) @(posedge clock);
            wb(1'b0, PRIO_MISC_OFFSET, rst_val[k%4]);
            dec(16'he000, 1'b0, 1'b0, (!k[0] || k[2]) ? 6'h02 : 6'h01);
            dec(16'hbf00, 1'b0, 1'b0, k%4 == 0 ? 6'h08 : 6'h01);
            $display("mode case %0d done", k);
        end
        rst(2'b10, 1'b1);
        wb(1'b1, PRIO_MISC_OFFSET, 8'hff);
        wb(1'b0, PRIO_MISC_OFFSET, 8'h3f);
        chk("clock pin", 32'h0, bus_clock_pin);
        r = xs();
        wb(1'b1, PRIO_MISC_OFFSET, {4'h0, r[3:0]});
        wb(1'b0, PRIO_MISC_OFFSET, {4'h3, r[3:0]});
        chk("priority", r[3:0], priority_select);
        wb(1'b0, 16'h1000, 8'h00);
        dec(16'h1000, 1'b1, 1'b1, 6'h20);
        dec(16'he000, 1'b0, 1'b1, 6'h10);
        dec(16'hb600, 1'b0, 1'b0, 6'h04);
        dec(16'hb7ff, 1'b0, 1'b0, 6'h04);
        dec(16'hb800, 1'b0, 1'b0, 6'h01);
        $display("single chip case done");
        rst(2'b00, 1'b0);
        wb(1'b1, PRIO_MISC_OFFSET, 8'h46);
        wb(1'b0, PRIO_MISC_OFFSET, 8'h46);
        wb(1'b1, PRIO_MISC_OFFSET, 8'he6);
        wb(1'b0, PRIO_MISC_OFFSET, 8'he6);
        dec(16'hbfff, 1'b0, 1'b0, 6'h08);
        wb(1'b1, PRIO_MISC_OFFSET, 8'h06);
        wb(1'b0, PRIO_MISC_OFFSET, 8'h06);
        dec(16'hbf00, 1'b0, 1'b0, 6'h01);
        wb(1'b1, PRIO_MISC_OFFSET, 8'h66);
        wb(1'b0, PRIO_MISC_OFFSET, 8'h06);
        $display("bootstrap case done");
        stop_test();
    end
endmodule

bind memory_map_and_mode_select mem_map_sva
    #(.LARGE_EEPROM(LARGE_EEPROM)) u_sva (.*);
